// file: logic/asid_setting_decoder.sv
// Decoder and executor for the actuator setting instructions of the microcores.
// Operation
// - End-of-actuation opcode on bits 15..3; bit 2 mask, bits 1..0 bootstrap switch.
// - Switch applies to each permitted high side: keep, force off, allow on, neutral.
// - Mask set forces source threshold monitoring off; clear leaves it, default clear.
// - Bootstrap switch setting resets to neutral and stays until changed.
// - Flag instruction drives one of sixteen flags, picked by index, to level.
// - Flag opcode on bits 15..5; bit 4 level, bits 3..0 index.
// - Freewheel operand picks manual or automatic; manual after reset.
// - Automatic freewheel output follows first shortcut by fixed high side table.
// - Freewheel link register chooses between two freewheel outputs per high side.
// - Freewheel mode changes only with drive rights on the first shortcut output.
// - Freewheel opcode on bits 15..1; bit 0 manual or automatic.
// - Gain codes 00..11 give 5.8, 8.7, about 12.5, 19.3.
// - Every amplifier gain resets to 5.8.
// - Selector picks own, other core, same core other channel, other both.
// - Gain write needs access right bits in the block access registers.
// - Other channel choice comes from a bit of the shared config registers.
// - Gain opcode on bits 15..4; bits 3..2 gain, bits 1..0 selector.
module asid_setting_decoder (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        srst,
   // Instruction from the sequencer
   input  wire logic        instr_valid,
   input  wire logic [15:0] instr_word,
   input  wire logic        exec_channel,
   input  wire logic        exec_core,
   // Drive rights and shortcuts of every microcore, index channel*2+core
   input  wire logic [47:0] drive_rights,
   input  wire logic [15:0] first_shortcut_output,
   // Configuration register port
   input  wire logic        cfg_wr,
   input  wire logic        cfg_rd,
   input  wire logic [8:0]  cfg_addr,
   input  wire logic [15:0] cfg_wdata,
   output logic      [15:0] cfg_rdata,
   // Execution status
   output logic             instr_done,
   output logic             instr_rejected,
   // Settings towards predriver, flag and current measurement blocks
   output logic      [63:0] flag_bits,
   output logic      [9:0]  hs_bootstrap_mode,
   output logic      [4:0]  hs_source_mask,
   output logic      [3:0]  freewheel_ctrl_mode,
   output logic      [15:0] freewheel_output,
   output logic      [7:0]  amp_gain
);

   // Decoded instruction.
   logic       hit_eoa;
   logic       hit_flag;
   logic       hit_fw;
   logic       hit_gain;
   logic       eoa_mask;
   logic [1:0] eoa_switch;
   logic       flag_level;
   logic [3:0] flag_index;
   logic       fw_mode;
   logic [1:0] gain_code;
   logic [1:0] amp_sel;

   asid_decode u_decode (
      .instr_valid (instr_valid),
      .instr_word  (instr_word),
      .hit_eoa     (hit_eoa),
      .hit_flag    (hit_flag),
      .hit_fw      (hit_fw),
      .hit_gain    (hit_gain),
      .eoa_mask    (eoa_mask),
      .eoa_switch  (eoa_switch),
      .flag_level  (flag_level),
      .flag_index  (flag_index),
      .fw_mode     (fw_mode),
      .gain_code   (gain_code),
      .amp_sel     (amp_sel)
   );

   // Settings state.
   logic [15:0]            flags         [asid_pkg::NUM_CORES];
   asid_pkg::asid_gain_t   gains         [asid_pkg::NUM_CORES];
   asid_pkg::asid_fw_t     fw_modes      [asid_pkg::NUM_CORES];
   logic [3:0]             fw_outs       [asid_pkg::NUM_CORES];
   asid_pkg::asid_switch_t bs_modes      [asid_pkg::NUM_HS];
   logic [4:0]             src_mask;
   logic                   done;
   logic                   rejected;
   logic [15:0]            cfg_shared    [2];
   logic [15:0]            freewheel_link_config;
   logic [15:0]            blk_access    [2];
   logic [15:0]            rdata;

   logic [15:0]            next_flags    [asid_pkg::NUM_CORES];
   asid_pkg::asid_gain_t   next_gains    [asid_pkg::NUM_CORES];
   asid_pkg::asid_fw_t     next_fw_modes [asid_pkg::NUM_CORES];
   logic [3:0]             next_fw_outs  [asid_pkg::NUM_CORES];
   asid_pkg::asid_switch_t next_bs_modes [asid_pkg::NUM_HS];
   logic [4:0]             next_src_mask;
   logic                   next_done;
   logic                   next_rejected;
   logic [15:0]            next_cfg_shared [2];
   logic [15:0]            next_freewheel_link_config;
   logic [15:0]            next_blk_access [2];
   logic [15:0]            next_rdata;

   // Freewheel predriver for a given first shortcut output and link setting.
   function automatic logic [3:0] fw_target(input logic [3:0] sc, input logic [15:0] link);
      logic [3:0] t;
      t = asid_pkg::OUT_NONE;
      case (sc)
         asid_pkg::OUT_HS1: t = link[0] ? asid_pkg::OUT_LS1 : asid_pkg::OUT_LS5;
         asid_pkg::OUT_HS2: t = link[1] ? asid_pkg::OUT_LS2 : asid_pkg::OUT_LS6;
         asid_pkg::OUT_HS3: t = link[2] ? asid_pkg::OUT_LS3 : asid_pkg::OUT_LS7;
         asid_pkg::OUT_HS4: t = link[3] ? asid_pkg::OUT_LS4 : asid_pkg::OUT_HS5;
         asid_pkg::OUT_HS5: t = link[4] ? asid_pkg::OUT_LS5 : asid_pkg::OUT_LS4;
         default:           t = asid_pkg::OUT_NONE;
      endcase
      fw_target = t;
   endfunction : fw_target

   // Core index within the four microcores.
   function automatic logic [1:0] core_idx(input logic chan, input logic core);
      core_idx = {chan, core};
   endfunction : core_idx

   // Decoding helpers.
   logic [1:0]  exec_idx;
   logic [11:0] exec_rights;
   logic [3:0]  exec_sc;
   logic        other_chan;
   logic        tgt_chan;
   logic        tgt_core;
   logic [1:0]  tgt_idx;
   logic        gain_ok;
   logic        fw_ok;

   always_comb begin
      exec_idx    = core_idx(exec_channel, exec_core);
      exec_rights = drive_rights[exec_idx * asid_pkg::NUM_OUTS +: asid_pkg::NUM_OUTS];
      exec_sc     = first_shortcut_output[exec_idx * 4 +: 4];
      // A set bit turns the other-channel selection back onto the own channel.
      other_chan  = cfg_shared[exec_channel][asid_pkg::OTHER_CHAN_BIT] ?
                    exec_channel : ~exec_channel;
      tgt_chan    = amp_sel[1] ? other_chan : exec_channel;
      tgt_core    = amp_sel[0] ? ~exec_core : exec_core;
      tgt_idx     = core_idx(tgt_chan, tgt_core);
      gain_ok     = blk_access[exec_channel][{exec_core, tgt_idx}];
      // An undefined shortcut carries no drive right, so the mode cannot change.
      fw_ok       = (exec_sc < 4'(asid_pkg::NUM_OUTS)) && exec_rights[exec_sc];
   end

   // Per-core settings written by the flag, freewheel and gain instructions.
   always_comb begin
      next_flags    = flags;
      next_gains    = gains;
      next_fw_modes = fw_modes;

      if (hit_flag) begin
         next_flags[exec_idx][flag_index] = flag_level;
      end
      if (hit_fw && fw_ok) begin
         next_fw_modes[exec_idx] = asid_pkg::asid_fw_t'(fw_mode);
      end
      if (hit_gain && gain_ok) begin
         next_gains[tgt_idx] = asid_pkg::asid_gain_t'(gain_code);
      end
      // The freewheel target tracks the live shortcut and link settings.
      for (int c = 0; c < asid_pkg::NUM_CORES; c++) begin
         next_fw_outs[c] = (next_fw_modes[c] == asid_pkg::FW_AUTO) ?
                           fw_target(first_shortcut_output[c * 4 +: 4], next_freewheel_link_config) :
                           asid_pkg::OUT_NONE;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         for (int c = 0; c < asid_pkg::NUM_CORES; c++) begin
            flags[c]    <= 16'h0000;
            gains[c]    <= asid_pkg::GAIN_5P8;
            fw_modes[c] <= asid_pkg::FW_MANUAL;
            fw_outs[c]  <= asid_pkg::OUT_NONE;
         end
      end else begin
         flags    <= next_flags;
         gains    <= next_gains;
         fw_modes <= next_fw_modes;
         fw_outs  <= next_fw_outs;
      end
   end

   // High-side settings are shared by all cores and written by any core with the right.
   always_comb begin
      next_bs_modes = bs_modes;
      next_src_mask = src_mask;
      // Keep leaves the bootstrap mode alone, but the mask is still written.
      if (hit_eoa) begin
         for (int i = 0; i < asid_pkg::NUM_HS; i++) begin
            if (exec_rights[i]) begin
               if (asid_pkg::asid_switch_t'(eoa_switch) != asid_pkg::SW_KEEP) begin
                  next_bs_modes[i] = asid_pkg::asid_switch_t'(eoa_switch);
               end
               next_src_mask[i] = eoa_mask;
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         for (int i = 0; i < asid_pkg::NUM_HS; i++) begin
            bs_modes[i] <= asid_pkg::SW_NEUTRAL;
         end
         src_mask <= 5'h00;
      end else begin
         bs_modes <= next_bs_modes;
         src_mask <= next_src_mask;
      end
   end

   // Execution status.
   always_comb begin
      // Each instruction completes in one cycle, so the sequencer never waits.
      next_done     = instr_valid && (hit_eoa || hit_flag || hit_fw || hit_gain);
      next_rejected = (hit_fw && !fw_ok) || (hit_gain && !gain_ok);
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         done     <= 1'b0;
         rejected <= 1'b0;
      end else begin
         done     <= next_done;
         rejected <= next_rejected;
      end
   end

   // Configuration registers; a read in the cycle of a write returns the old value.
   always_comb begin
      next_cfg_shared = cfg_shared;
      next_freewheel_link_config    = freewheel_link_config;
      next_blk_access = blk_access;
      next_rdata      = rdata;

      if (cfg_wr) begin
         case (cfg_addr)
            asid_pkg::ADDR_DAC_SHARED_CONFIG_CH1:  next_cfg_shared[0] = cfg_wdata;
            asid_pkg::ADDR_DAC_SHARED_CONFIG_CH2:  next_cfg_shared[1] = cfg_wdata;
            asid_pkg::ADDR_FREEWHEEL_LINK_CONFIG:  next_freewheel_link_config       = cfg_wdata;
            asid_pkg::ADDR_CURRENT_BLOCK_ACCESS_1: next_blk_access[0] = cfg_wdata;
            asid_pkg::ADDR_CURRENT_BLOCK_ACCESS_2: next_blk_access[1] = cfg_wdata;
            default:                               next_freewheel_link_config       = freewheel_link_config;
         endcase
      end
      if (cfg_rd) begin
         case (cfg_addr)
            asid_pkg::ADDR_DAC_SHARED_CONFIG_CH1:  next_rdata = cfg_shared[0];
            asid_pkg::ADDR_DAC_SHARED_CONFIG_CH2:  next_rdata = cfg_shared[1];
            asid_pkg::ADDR_FREEWHEEL_LINK_CONFIG:  next_rdata = freewheel_link_config;
            asid_pkg::ADDR_CURRENT_BLOCK_ACCESS_1: next_rdata = blk_access[0];
            asid_pkg::ADDR_CURRENT_BLOCK_ACCESS_2: next_rdata = blk_access[1];
            default:                               next_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         // All access bits clear at reset, so gain writes are refused until granted.
         cfg_shared[0] <= asid_pkg::RST_CONFIG;
         cfg_shared[1] <= asid_pkg::RST_CONFIG;
         freewheel_link_config       <= asid_pkg::RST_CONFIG;
         blk_access[0] <= asid_pkg::RST_CONFIG;
         blk_access[1] <= asid_pkg::RST_CONFIG;
         rdata         <= 16'h0000;
      end else begin
         cfg_shared <= next_cfg_shared;
         freewheel_link_config    <= next_freewheel_link_config;
         blk_access <= next_blk_access;
         rdata      <= next_rdata;
      end
   end

   // Output packing.
   always_comb begin
      for (int c = 0; c < asid_pkg::NUM_CORES; c++) begin
         flag_bits[c * 16 +: 16]       = flags[c];
         amp_gain[c * 2 +: 2]          = gains[c];
         freewheel_ctrl_mode[c]        = fw_modes[c];
         freewheel_output[c * 4 +: 4]  = fw_outs[c];
      end
      for (int i = 0; i < asid_pkg::NUM_HS; i++) begin
         hs_bootstrap_mode[i * 2 +: 2] = bs_modes[i];
      end
   end

   assign hs_source_mask = src_mask;
   assign instr_done     = done;
   assign instr_rejected = rejected;
   assign cfg_rdata      = rdata;

endmodule : asid_setting_decoder

// file: logic/asid_pkg.sv
// Constants, field layouts and types shared by the setting-instruction decoder.
package asid_pkg;

   // Opcode masks and match patterns for the four setting instructions.
   localparam logic [15:0] OP_EOA_MASK   = 16'hFFF8;
   localparam logic [15:0] OP_EOA_MATCH  = 16'h3520;
   localparam logic [15:0] OP_FLAG_MASK  = 16'hFFE0;
   localparam logic [15:0] OP_FLAG_MATCH = 16'h34E0;
   localparam logic [15:0] OP_FW_MASK    = 16'hFFFE;
   localparam logic [15:0] OP_FW_MATCH   = 16'h3590;
   localparam logic [15:0] OP_GAIN_MASK  = 16'hFFF0;
   localparam logic [15:0] OP_GAIN_MATCH = 16'h3530;

   // Operand field positions.
   localparam int EOA_MASK_BIT   = 2;
   localparam int EOA_SWITCH_LSB = 0;
   localparam int FLAG_LEVEL_BIT = 4;
   localparam int FLAG_INDEX_LSB = 0;
   localparam int FW_MODE_BIT    = 0;
   localparam int GAIN_CODE_LSB  = 2;
   localparam int AMP_SEL_LSB    = 0;

   // Configuration register offsets.
   localparam logic [8:0] ADDR_DAC_SHARED_CONFIG_CH1 = 9'h112;
   localparam logic [8:0] ADDR_DAC_SHARED_CONFIG_CH2 = 9'h132;
   localparam logic [8:0] ADDR_FREEWHEEL_LINK_CONFIG = 9'h169;
   localparam logic [8:0] ADDR_CURRENT_BLOCK_ACCESS_1 = 9'h188;
   localparam logic [8:0] ADDR_CURRENT_BLOCK_ACCESS_2 = 9'h189;

   // Configuration reset values and field positions.
   localparam logic [15:0] RST_CONFIG     = 16'h0000;
   localparam int          OTHER_CHAN_BIT = 0;

   // Sizes.
   localparam int NUM_CORES = 4;
   localparam int NUM_HS    = 5;
   localparam int NUM_OUTS  = 12;
   localparam int NUM_FLAGS = 16;

   // Predriver output indices.
   localparam logic [3:0] OUT_HS1  = 4'h0;
   localparam logic [3:0] OUT_HS2  = 4'h1;
   localparam logic [3:0] OUT_HS3  = 4'h2;
   localparam logic [3:0] OUT_HS4  = 4'h3;
   localparam logic [3:0] OUT_HS5  = 4'h4;
   localparam logic [3:0] OUT_LS1  = 4'h5;
   localparam logic [3:0] OUT_LS2  = 4'h6;
   localparam logic [3:0] OUT_LS3  = 4'h7;
   localparam logic [3:0] OUT_LS4  = 4'h8;
   localparam logic [3:0] OUT_LS5  = 4'h9;
   localparam logic [3:0] OUT_LS6  = 4'hA;
   localparam logic [3:0] OUT_LS7  = 4'hB;
   localparam logic [3:0] OUT_NONE = 4'hF;

   // Bootstrap switch setting, in operand encoding order.
   typedef enum logic [1:0] {SW_KEEP, SW_BSOFF, SW_BSON, SW_NEUTRAL} asid_switch_t;

   // Amplifier gain code, in operand encoding order.
   typedef enum logic [1:0] {GAIN_5P8, GAIN_8P7, GAIN_12P5, GAIN_19P3} asid_gain_t;

   // Freewheel control mode.
   typedef enum logic {FW_MANUAL, FW_AUTO} asid_fw_t;

endpackage : asid_pkg

// file: logic/asid_decode.sv
// Opcode match and operand extraction for the four setting instructions.
module asid_decode (
   // Instruction word
   input  wire logic        instr_valid,
   input  wire logic [15:0] instr_word,
   // Decoded instruction
   output logic             hit_eoa,
   output logic             hit_flag,
   output logic             hit_fw,
   output logic             hit_gain,
   // Decoded operands
   output logic             eoa_mask,
   output logic [1:0]       eoa_switch,
   output logic             flag_level,
   output logic [3:0]       flag_index,
   output logic             fw_mode,
   output logic [1:0]       gain_code,
   output logic [1:0]       amp_sel
);

   function automatic logic op_match(input logic [15:0] w, input logic [15:0] m,
                                     input logic [15:0] p);
      op_match = ((w & m) == p);
   endfunction : op_match

   assign hit_eoa  = instr_valid && op_match(instr_word, asid_pkg::OP_EOA_MASK,
                                             asid_pkg::OP_EOA_MATCH);
   assign hit_flag = instr_valid && op_match(instr_word, asid_pkg::OP_FLAG_MASK,
                                             asid_pkg::OP_FLAG_MATCH);
   assign hit_fw   = instr_valid && op_match(instr_word, asid_pkg::OP_FW_MASK,
                                             asid_pkg::OP_FW_MATCH);
   assign hit_gain = instr_valid && op_match(instr_word, asid_pkg::OP_GAIN_MASK,
                                             asid_pkg::OP_GAIN_MATCH);

   assign eoa_mask   = instr_word[asid_pkg::EOA_MASK_BIT];
   assign eoa_switch = instr_word[asid_pkg::EOA_SWITCH_LSB +: 2];
   assign flag_level = instr_word[asid_pkg::FLAG_LEVEL_BIT];
   assign flag_index = instr_word[asid_pkg::FLAG_INDEX_LSB +: 4];
   assign fw_mode    = instr_word[asid_pkg::FW_MODE_BIT];
   assign gain_code  = instr_word[asid_pkg::GAIN_CODE_LSB +: 2];
   assign amp_sel    = instr_word[asid_pkg::AMP_SEL_LSB +: 2];

endmodule : asid_decode

// file: test/asid_checker_sva.sv
// Port-level assertions for the setting-instruction decoder.
module asid_checker_sva (
   // Clock and reset
   input wire logic        clock,
   input wire logic        srst,
   // Instruction side
   input wire logic        instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic        exec_channel,
   input wire logic        exec_core,
   input wire logic [15:0] first_shortcut_output,
   // Results
   input wire logic        instr_done,
   input wire logic        instr_rejected,
   input wire logic [63:0] flag_bits,
   input wire logic [9:0]  hs_bootstrap_mode,
   input wire logic [3:0]  freewheel_ctrl_mode,
   input wire logic [15:0] freewheel_output,
   input wire logic [7:0]  amp_gain
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);
   logic       is_eoa;
   logic       is_flag;
   logic       is_fw;
   logic       is_gain;
   logic [3:0] sc;
   logic [6:0] next_fl;
   logic [6:0] fl;
   assign is_eoa = instr_valid && (instr_word & 16'hFFF8) == 16'h3520;
   assign is_flag = instr_valid && (instr_word & 16'hFFE0) == 16'h34E0;
   assign is_fw = instr_valid && (instr_word & 16'hFFFE) == 16'h3590;
   assign is_gain = instr_valid && (instr_word & 16'hFFF0) == 16'h3530;
   assign sc = first_shortcut_output[{exec_channel, exec_core, 2'b00} +: 4];
   assign next_fl = {instr_word[4], exec_channel, exec_core, instr_word[3:0]};
   // The flag target is kept one cycle, where its new level must show.
   always_ff @(posedge clock) begin
      fl <= next_fl;
   end
   a_eoa_done: assert property (is_eoa |=> instr_done && !instr_rejected)
      else $error("eoa word not completed");
   a_flag_level: assert property (is_flag |=> flag_bits[fl[5:0]] == fl[6])
      else $error("flag level wrong");
   a_fw_refuse: assert property (is_fw && sc >= 4'hC |=>
      instr_rejected && $stable(freewheel_ctrl_mode)) else $error("fw without shortcut");
   a_reject_done: assert property (instr_rejected |-> instr_done)
      else $error("reject without done");
   a_idle_quiet: assert property (!instr_valid |=> !instr_done)
      else $error("done without word");
   a_gain_hold: assert property (!is_gain |=> $stable(amp_gain))
      else $error("gain moved");
   a_reset_state: assert property ($fell(srst) |-> hs_bootstrap_mode == 10'h3FF
      && freewheel_ctrl_mode == 4'h0 && amp_gain == 8'h00) else $error("bad reset state");
   a_manual_idle: assert property (!freewheel_ctrl_mode[0] |-> freewheel_output[3:0] == 4'hF)
      else $error("manual core shows freewheel output");
endmodule : asid_checker_sva

bind asid_setting_decoder asid_checker_sva u_sva (.clock(clock), .srst(srst),
   .instr_valid(instr_valid), .instr_word(instr_word), .exec_channel(exec_channel),
   .exec_core(exec_core), .first_shortcut_output(first_shortcut_output),
   .instr_done(instr_done), .instr_rejected(instr_rejected), .flag_bits(flag_bits),
   .hs_bootstrap_mode(hs_bootstrap_mode), .freewheel_ctrl_mode(freewheel_ctrl_mode),
   .freewheel_output(freewheel_output), .amp_gain(amp_gain));

// file: test/asid_seq_model.sv
// Behavioural microcore sequencer issuing one instruction word per request.
module asid_seq_model (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        srst,
   // Requests from the bench
   input  wire logic        req,
   input  wire logic [15:0] req_word,
   input  wire logic [1:0]  req_id,
   // Instruction bus towards the decoder
   output logic             instr_valid,
   output logic      [15:0] instr_word,
   output logic             exec_channel,
   output logic             exec_core
);
   timeunit 1ns;
   timeprecision 1ps;
   // Each idle cycle carries the inverse of the word of the cycle before, so nothing stale can pass as valid.
   always_ff @(posedge clock) begin
      if (srst) begin
         instr_valid <= 1'b0;
         instr_word <= 16'h0000;
         {exec_channel, exec_core} <= 2'h0;
      end else begin
         instr_valid <= req;
         instr_word <= req ? req_word : ~instr_word;
         {exec_channel, exec_core} <= req ? req_id : ~{exec_channel, exec_core};
      end
   end
endmodule : asid_seq_model

// file: test/tb_asid_setting_decoder.sv
// Self-checking bench for the actuator setting-instruction decoder.
module tb_asid_setting_decoder;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock, srst, req, instr_valid, exec_channel, exec_core, cfg_wr, cfg_rd;
   logic        instr_done, instr_rejected, got_done, got_rej;
   logic [1:0]  req_id;
   logic [8:0]  cfg_addr;
   logic [15:0] req_word, instr_word, first_shortcut_output, cfg_wdata, cfg_rdata;
   logic [15:0] freewheel_output;
   logic [47:0] drive_rights;
   logic [63:0] flag_bits;
   logic [9:0]  hs_bootstrap_mode;
   logic [4:0]  hs_source_mask;
   logic [3:0]  freewheel_ctrl_mode;
   logic [7:0]  amp_gain;
   int          errors, n_tests;

   asid_seq_model seq (.clock(clock), .srst(srst), .req(req), .req_word(req_word),
      .req_id(req_id), .instr_valid(instr_valid), .instr_word(instr_word),
      .exec_channel(exec_channel), .exec_core(exec_core));
   asid_setting_decoder uut (.clock(clock), .srst(srst), .instr_valid(instr_valid),
      .instr_word(instr_word), .exec_channel(exec_channel), .exec_core(exec_core),
      .drive_rights(drive_rights), .first_shortcut_output(first_shortcut_output),
      .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata), .instr_done(instr_done), .instr_rejected(instr_rejected),
      .flag_bits(flag_bits), .hs_bootstrap_mode(hs_bootstrap_mode),
      .hs_source_mask(hs_source_mask), .freewheel_ctrl_mode(freewheel_ctrl_mode),
      .freewheel_output(freewheel_output), .amp_gain(amp_gain));

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task automatic check(input logic ok, input string what);
      n_tests++;
      if (ok !== 1'b1) begin
         errors++;
         $display("FAIL %0t %s", $time, what);
      end
   endtask : check

   // One word through the sequencer; returns once the answer has settled.
   task automatic issue(input logic [15:0] w, input logic [1:0] id);
      req_word = w;
      req_id = id;
      req = 1'b1;
      @(posedge clock);
      #1 req = 1'b0;
      @(posedge clock);
      #1 got_done = instr_done;
      got_rej = instr_rejected;
   endtask : issue

   task automatic cfg_write(input logic [8:0] a, input logic [15:0] d);
      cfg_addr = a;
      cfg_wdata = d;
      cfg_wr = 1'b1;
      @(posedge clock);
      #1 cfg_wr = 1'b0;
   endtask : cfg_write

   task automatic cfg_expect(input logic [8:0] a, input logic [15:0] d);
      cfg_addr = a;
      cfg_rd = 1'b1;
      @(posedge clock);
      #1 cfg_rd = 1'b0;
      check(cfg_rdata === d, "config read");
   endtask : cfg_expect

   task automatic finish_test;
      $display("errors %0d n_tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test

   task automatic t_reset;
      check(flag_bits === 64'h0 && hs_source_mask === 5'h00, "flags or mask");
      check(hs_bootstrap_mode === 10'h3FF, "bootstrap not neutral");
      check(freewheel_ctrl_mode === 4'h0 && freewheel_output === 16'hFFFF, "not manual");
      check(amp_gain === 8'h00, "gain not lowest");
   endtask : t_reset

   task automatic t_config;
      logic [8:0] ad [5] = '{9'h112, 9'h132, 9'h169, 9'h188, 9'h189};
      foreach (ad[i]) begin
         cfg_expect(ad[i], 16'h0000);
         cfg_write(ad[i], 16'hA5C0 ^ 16'(i));
         cfg_expect(ad[i], 16'hA5C0 ^ 16'(i));
         cfg_write(ad[i], 16'h0000);
      end
      cfg_write(9'h100, 16'hFFFF);
      cfg_expect(9'h100, 16'h0000);
   endtask : t_config

   task automatic t_flags;
      logic [3:0]  ix [4] = '{4'h0, 4'hF, 4'h7, 4'hF};
      logic        lv [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
      logic [63:0] ex;
      ex = 64'h0;
      for (int i = 0; i < 4; i++) begin
         issue(16'h34E0 | {11'h0, lv[i], ix[i]}, 2'h3);
         ex[48 + ix[i]] = lv[i];
         check(got_done === 1'b1 && flag_bits === ex, "flag write");
      end
      issue(16'h34C3, 2'h3);
      check(got_done === 1'b0 && flag_bits === ex, "near-miss word acted");
   endtask : t_flags

   task automatic t_eoa;
      logic [1:0] sw [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
      logic [9:0] eb;
      logic [4:0] em;
      eb = 10'h3FF;
      em = 5'h00;
      drive_rights = 48'h3;
      for (int i = 0; i < 4; i++) begin
         issue(16'h3520 | {13'h0, sw[i][0], sw[i]}, 2'h0);
         if (sw[i] != 2'h0) begin
            eb[3:0] = {sw[i], sw[i]};
         end
         em[1:0] = {2{sw[i][0]}};
         check(hs_bootstrap_mode === eb, "bootstrap mode");
         check(got_done === 1'b1 && hs_source_mask === em, "source mask");
      end
   endtask : t_eoa

   task automatic t_fw;
      logic [3:0] tb_[10] = '{4'h9, 4'hA, 4'hB, 4'h4, 4'h8, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
      drive_rights = 48'h1F;
      for (int l = 0; l < 2; l++) begin
         cfg_write(9'h169, l == 0 ? 16'h0000 : 16'h001F);
         for (int k = 0; k < 5; k++) begin
            first_shortcut_output = {12'hFFF, 4'(k)};
            issue(16'h3591, 2'h0);
            check(freewheel_ctrl_mode === 4'h1 && got_rej === 1'b0, "auto mode");
            check(freewheel_output === {12'hFFF, tb_[l * 5 + k]}, "fw output");
         end
      end
      first_shortcut_output = 16'hFFF5;
      issue(16'h3590, 2'h0);
      check(got_rej === 1'b1 && freewheel_ctrl_mode === 4'h1, "no drive right");
      first_shortcut_output = 16'hFFFF;
      issue(16'h3590, 2'h0);
      check(got_done === 1'b1 && freewheel_ctrl_mode === 4'h1, "refused");
      first_shortcut_output = 16'hFFF0;
      issue(16'h3590, 2'h0);
      check(freewheel_ctrl_mode === 4'h0 && freewheel_output === 16'hFFFF, "manual");
   endtask : t_fw

   task automatic t_gain;
      logic [7:0] eg;
      logic [1:0] cd;
      eg = 8'h00;
      issue(16'h353C, 2'h0);
      check(got_rej === 1'b1 && amp_gain === eg, "gain without access");
      cfg_write(9'h188, 16'h000F);
      for (int s = 0; s < 4; s++) begin
         cd = 2'(s + 1);
         issue(16'h3530 | {12'h0, cd, 2'(s)}, 2'h0);
         eg[s * 2 +: 2] = cd;
         check(got_rej === 1'b0 && amp_gain === eg, "gain write");
      end
      cfg_write(9'h112, 16'h0001);
      issue(16'h353E, 2'h0);
      eg[1:0] = 2'h3;
      check(amp_gain === eg, "other channel choice");
      issue(16'h3534, 2'h1);
      check(got_rej === 1'b1 && amp_gain === eg, "core one without access");
   endtask : t_gain

   initial begin
      {req, req_id, req_word, cfg_wr, cfg_rd, cfg_addr, cfg_wdata, drive_rights} = '0;
      first_shortcut_output = 16'hFFFF;
      errors = 0;
      n_tests = 0;
      srst = 1'b1;
      repeat (6) @(posedge clock);
      #1 srst = 1'b0;
      t_reset();
      t_config();
      t_flags();
      t_eoa();
      t_fw();
      t_gain();
      finish_test();
   end

   // The tests need well under a thousand cycles; this cuts a hang short.
   initial begin
      #50000;
      errors++;
      finish_test();
   end
endmodule : tb_asid_setting_decoder
